// [hdl/fed_pkg.sv]
/*
  Constants, field layouts and carrier types for the front-end diagnostics
  configuration bank. Assumes a 32-bit APB master and static analog controls.
*/
// Overview of operation
// - Current field codes 000/001/010/011 select 25, 50, 100, 500 uA excitation.
// - Current codes with top bit set switch source off; field resets to 100.
// - Selector 0000 routes external temperature pin pair; this is the reset value.
// - Selector 0011 routes on-chip sensor voltage referred to ground.
// - Mode bit 0 gives single-ended temperature stage, 1 differential; resets 0.
// - Diagnostics enable bit 0 disables diagnostics, 1 enables; resets 0.
// - Mask bit 7 enables temperature output undervoltage detection; resets 0.
// - Mask bit 6 enables temperature output overvoltage detection; resets 0.
// - Mask bit 5 enables pressure output undervoltage detection; resets 1.
// - Mask bit 4 enables pressure output overvoltage detection; resets 1.
// - Mask bit 2 enables temperature input overvoltage detection; resets 0.
// - Mask bit 1 enables pressure input undervoltage detection; resets 1.
// - Mask bit 0 enables pressure input overvoltage detection; resets 1.
// - Pull-up disable bit 1 turns temperature pin pull-ups off.
// - Pull-down disable bit 1 turns pressure pin pull-downs off.
package fed_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] FED_IDX_MODE = 8'h00;
  localparam logic [7:0] FED_IDX_DIAG = 8'h04;
  localparam logic [7:0] FED_IDX_CFG = 8'h06;
  localparam logic [7:0] FED_IDX_MASK = 8'h07;
  localparam logic [7:0] FED_IDX_TEMP = 8'h08;
  localparam logic [7:0] FED_IDX_STAT = 8'h09;
  localparam logic [7:0] FED_IDX_CLR = 8'h0A;
  localparam logic [7:0] FED_IDX_IEN = 8'h0B;

  localparam logic [7:0] FED_RST_MODE = 8'h00;
  localparam logic [7:0] FED_RST_DIAG = 8'h00;
  localparam logic [7:0] FED_RST_CFG = 8'h07;
  localparam logic [7:0] FED_RST_MASK = 8'h33;
  localparam logic [7:0] FED_RST_TEMP = 8'h40;

  // Reserved bit masks
  localparam logic [7:0] FED_RSV_MODE = 8'hFE;
  localparam logic [7:0] FED_RSV_DIAG = 8'hFE;
  localparam logic [7:0] FED_RSV_CFG = 8'h80;
  localparam logic [7:0] FED_RSV_MASK = 8'h08;
  localparam logic [7:0] FED_RSV_TEMP = 8'h80;

  localparam int FED_EXC_LSB = 4;
  localparam int FED_MUX_LSB = 0;
  localparam int FED_PUOFF_BIT = 6;
  localparam int FED_PDOFF_BIT = 5;
  localparam int FED_THR_LSB = 2;
  localparam int FED_PULL_LSB = 0;

  localparam logic [2:0] FED_EXC_25 = 3'h0;
  localparam logic [2:0] FED_EXC_50 = 3'h1;
  localparam logic [2:0] FED_EXC_100 = 3'h2;
  localparam logic [2:0] FED_EXC_500 = 3'h3;
  localparam logic [3:0] FED_MUX_EXT = 4'h0;
  localparam logic [3:0] FED_MUX_INT = 4'h3;

  // Event bits of status, clear and enable
  localparam int FED_EV_RSVD = 0;
  localparam int FED_EV_MUXBAD = 1;
  localparam int FED_EV_DIAGCHG = 2;
  localparam int FED_NEV = 3;

  typedef struct packed {
    logic [3:0] exc_onehot;
    logic exc_off;
    logic route_ext;
    logic route_int;
    logic temp_stage_mode_bit;
    logic diag_global_on;
    logic temp_out_under_en;
    logic temp_out_over_en;
    logic press_out_under_en;
    logic press_out_over_en;
    logic temp_in_over_en;
    logic press_in_under_en;
    logic press_in_over_en;
    logic temp_pullup_off;
    logic press_pulldown_off;
    logic [2:0] diag_threshold_sel;
    logic [1:0] diag_pull_strength;
  } fed_afe_ctl_t;

endpackage

// [hdl/fed_exc_dec.sv]
/*
  Registered decoder of the excitation current field into one-hot current
  selects. Assumes the code comes from a register on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fed_exc_dec
  import fed_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] code,
  output logic [3:0] onehot_r,
  output logic off_r
);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      onehot_r <= 4'h0;
      off_r <= 1'b1;
    end
    else
    begin
      off_r <= code[2];
      case (code)
        FED_EXC_25: onehot_r <= 4'h1;
        FED_EXC_50: onehot_r <= 4'h2;
        FED_EXC_100: onehot_r <= 4'h4;
        FED_EXC_500: onehot_r <= 4'h8;
        default: onehot_r <= 4'h0;
      endcase
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_exc_500;
    code == FED_EXC_500 |=> onehot_r == 4'h8 && !off_r;
  endproperty
  a_exc_500: assert property (p_exc_500) else $error("500 uA code not decoded");

  property p_exc_25;
    code == FED_EXC_25 |=> onehot_r == 4'h1 && !off_r;
  endproperty
  a_exc_25: assert property (p_exc_25) else $error("25 uA code not decoded");

  property p_exc_off;
    code[2] |=> off_r && onehot_r == 4'h0;
  endproperty
  a_exc_off: assert property (p_exc_off) else $error("source not off for top-bit code");

endmodule
`default_nettype wire

// [hdl/fed_irq.sv]
/*
  Sticky event status with enable mask and write-one-to-clear. Assumes events
  and register strobes are single-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fed_irq
  import fed_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [FED_NEV-1:0] events,
  input wire logic clr_wr,
  input wire logic ien_wr,
  input wire logic [FED_NEV-1:0] wdata,
  output logic [FED_NEV-1:0] status_r,
  output logic [FED_NEV-1:0] ien_r,
  output logic irq_r
);

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      status_r <= '0;
    else
      status_r <= (status_r & ~(clr_wr ? wdata : '0)) | events;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ien_r <= '0;
    else if (ien_wr)
      ien_r <= wdata;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_r <= 1'b0;
    else
      irq_r <= |(((status_r & ~(clr_wr ? wdata : '0)) | events) & (ien_wr ? wdata : ien_r));
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_set_wins;
    events[0] && clr_wr && wdata[0] |=> status_r[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost against clear");

  property p_irq_level;
    ##1 irq_r == |(status_r & ien_r);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level mismatch");

endmodule
`default_nettype wire

// [hdl/fed_top.sv]
/*
  APB register bank for the sensor front-end diagnostics configuration and
  its decode into static analog control levels. Assumes an APB master on clk
  and analog circuits that take the control levels without resampling.
*/
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fed_top
  import fed_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic irq,
  output fed_afe_ctl_t afe_ctl
);

  logic [7:0] mode_r;
  logic [7:0] diag_r;
  logic [7:0] cfg_r;
  logic [7:0] mask_r;
  logic [7:0] temp_r;
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic route_ext_r;
  logic route_int_r;
  logic stage_mode_r;
  logic diag_on_r;
  logic [6:0] det_r;
  logic pullup_off_r;
  logic pulldown_off_r;
  logic [2:0] thr_r;
  logic [1:0] pull_r;
  logic [3:0] exc_onehot;
  logic exc_off;
  logic [FED_NEV-1:0] status;
  logic [FED_NEV-1:0] ien;
  logic irq_w;

  logic [7:0] idx;
  logic mapped;
  logic [7:0] rsv_mask;
  logic [7:0] rd_byte;
  logic access;
  logic fire;
  logic wr_fire;
  logic [7:0] wbyte;
  logic [FED_NEV-1:0] events;
  logic [6:0] det_sel;

  assign idx = paddr[9:2];
  assign access = psel && penable;
  // The write lands at the edge where the master sees pready high
  assign fire = access && pready_r;
  assign wr_fire = fire && pwrite && mapped;
  assign wbyte = pwdata[7:0];

  always_comb
  begin
    rsv_mask = 8'h00;
    rd_byte = 8'h00;
    mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    case (idx)
      FED_IDX_MODE:
      begin
        rsv_mask = FED_RSV_MODE;
        rd_byte = mode_r;
      end
      FED_IDX_DIAG:
      begin
        rsv_mask = FED_RSV_DIAG;
        rd_byte = diag_r;
      end
      FED_IDX_CFG:
      begin
        rsv_mask = FED_RSV_CFG;
        rd_byte = cfg_r;
      end
      FED_IDX_MASK:
      begin
        rsv_mask = FED_RSV_MASK;
        rd_byte = mask_r;
      end
      FED_IDX_TEMP:
      begin
        rsv_mask = FED_RSV_TEMP;
        rd_byte = temp_r;
      end
      FED_IDX_STAT:
        rd_byte = {{(8-FED_NEV){1'b0}}, status};
      FED_IDX_CLR:
        rd_byte = 8'h00;
      FED_IDX_IEN:
        rd_byte = {{(8-FED_NEV){1'b0}}, ien};
      default:
        mapped = 1'b0;
    endcase
  end

  // One wait state: data and error are registered on the same edge that raises pready
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pready_r <= 1'b0;
    else
      pready_r <= access && !pready_r;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (access && !pready_r)
    begin
      prdata_r <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      pslverr_r <= !mapped;
    end
    else
    begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
  end

  // Reserved bits are not stored, so they read back as zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode_r <= FED_RST_MODE;
      diag_r <= FED_RST_DIAG;
      cfg_r <= FED_RST_CFG;
      mask_r <= FED_RST_MASK;
      temp_r <= FED_RST_TEMP;
    end
    else if (wr_fire)
    begin
      case (idx)
        FED_IDX_MODE: mode_r <= wbyte & ~FED_RSV_MODE;
        FED_IDX_DIAG: diag_r <= wbyte & ~FED_RSV_DIAG;
        FED_IDX_CFG: cfg_r <= wbyte & ~FED_RSV_CFG;
        FED_IDX_MASK: mask_r <= wbyte & ~FED_RSV_MASK;
        FED_IDX_TEMP: temp_r <= wbyte & ~FED_RSV_TEMP;
        default: mode_r <= mode_r;
      endcase
    end
  end

  // Software is expected to keep reserved bits zero; a breach is flagged
  always_comb
  begin
    events = '0;
    events[FED_EV_RSVD] = wr_fire && ((wbyte & rsv_mask) != 8'h00);
    events[FED_EV_MUXBAD] = wr_fire && (idx == FED_IDX_TEMP) &&
      (wbyte[FED_MUX_LSB +: 4] != FED_MUX_EXT) &&
      (wbyte[FED_MUX_LSB +: 4] != FED_MUX_INT);
    events[FED_EV_DIAGCHG] = wr_fire && ((idx == FED_IDX_DIAG) || (idx == FED_IDX_MASK));
  end

  fed_irq fed_irq_i (
    .clk(clk),
    .rst_n(rst_n),
    .events(events),
    .clr_wr(wr_fire && (idx == FED_IDX_CLR)),
    .ien_wr(wr_fire && (idx == FED_IDX_IEN)),
    .wdata(wbyte[FED_NEV-1:0]),
    .status_r(status),
    .ien_r(ien),
    .irq_r(irq_w)
  );

  fed_exc_dec fed_exc_dec_i (
    .clk(clk),
    .rst_n(rst_n),
    .code(temp_r[FED_EXC_LSB +: 3]),
    .onehot_r(exc_onehot),
    .off_r(exc_off)
  );

  // Undefined selector codes leave both sources disconnected
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      route_ext_r <= 1'b1;
      route_int_r <= 1'b0;
    end
    else
    begin
      route_ext_r <= temp_r[FED_MUX_LSB +: 4] == FED_MUX_EXT;
      route_int_r <= temp_r[FED_MUX_LSB +: 4] == FED_MUX_INT;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage_mode_r <= 1'b0;
      diag_on_r <= 1'b0;
    end
    else
    begin
      stage_mode_r <= mode_r[0];
      diag_on_r <= diag_r[0];
    end
  end

  // Detection order: temp out UV/OV, press out UV/OV, temp in OV, press in UV/OV
  assign det_sel = {mask_r[7:4], mask_r[2:0]};

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_det
      always_ff @(posedge clk)
      begin
        if (!rst_n)
          det_r[gi] <= 1'b0;
        else
          det_r[gi] <= det_sel[gi] && diag_r[0];
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pullup_off_r <= 1'b0;
      pulldown_off_r <= 1'b0;
      thr_r <= FED_RST_CFG[FED_THR_LSB +: 3];
      pull_r <= FED_RST_CFG[FED_PULL_LSB +: 2];
    end
    else
    begin
      pullup_off_r <= cfg_r[FED_PUOFF_BIT];
      pulldown_off_r <= cfg_r[FED_PDOFF_BIT];
      thr_r <= cfg_r[FED_THR_LSB +: 3];
      pull_r <= cfg_r[FED_PULL_LSB +: 2];
    end
  end

  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign irq = irq_w;

  always_comb
  begin
    afe_ctl.exc_onehot = exc_onehot;
    afe_ctl.exc_off = exc_off;
    afe_ctl.route_ext = route_ext_r;
    afe_ctl.route_int = route_int_r;
    afe_ctl.temp_stage_mode_bit = stage_mode_r;
    afe_ctl.diag_global_on = diag_on_r;
    afe_ctl.temp_out_under_en = det_r[6];
    afe_ctl.temp_out_over_en = det_r[5];
    afe_ctl.press_out_under_en = det_r[4];
    afe_ctl.press_out_over_en = det_r[3];
    afe_ctl.temp_in_over_en = det_r[2];
    afe_ctl.press_in_under_en = det_r[1];
    afe_ctl.press_in_over_en = det_r[0];
    afe_ctl.temp_pullup_off = pullup_off_r;
    afe_ctl.press_pulldown_off = pulldown_off_r;
    afe_ctl.diag_threshold_sel = thr_r;
    afe_ctl.diag_pull_strength = pull_r;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_apb_wait;
    access && !pready_r |=> pready_r ##1 !pready_r;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("APB answer not after one wait state");

  property p_route_ext;
    temp_r[3:0] == FED_MUX_EXT |=> route_ext_r && !route_int_r;
  endproperty
  a_route_ext: assert property (p_route_ext) else $error("external pins not routed");

  property p_route_int;
    temp_r[3:0] == FED_MUX_INT |=> route_int_r && !route_ext_r;
  endproperty
  a_route_int: assert property (p_route_int) else $error("on-chip sensor not routed");

  property p_route_safe;
    temp_r[3:0] != FED_MUX_EXT && temp_r[3:0] != FED_MUX_INT |=> !route_int_r && !route_ext_r;
  endproperty
  a_route_safe: assert property (p_route_safe) else $error("reserved selector routed");

  property p_mode;
    wr_fire && idx == FED_IDX_MODE |=> ##1 stage_mode_r == $past(wbyte[0], 2);
  endproperty
  a_mode: assert property (p_mode) else $error("stage mode not applied");

  property p_diag_on;
    ##1 diag_on_r == $past(diag_r[0]);
  endproperty
  a_diag_on: assert property (p_diag_on) else $error("diagnostics enable mismatch");

  property p_gate_off;
    !diag_r[0] |=> det_r == 7'h00;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("detection active while disabled");

  property p_out_under;
    diag_r[0] && mask_r[7] |=> afe_ctl.temp_out_under_en;
  endproperty
  a_out_under: assert property (p_out_under) else $error("temp out UV not enabled");

  property p_out_over;
    diag_r[0] |=> afe_ctl.temp_out_over_en == $past(mask_r[6]) &&
      afe_ctl.press_out_under_en == $past(mask_r[5]) &&
      afe_ctl.press_out_over_en == $past(mask_r[4]);
  endproperty
  a_out_over: assert property (p_out_over) else $error("output detection mismatch");

  property p_in_det;
    diag_r[0] |=> afe_ctl.temp_in_over_en == $past(mask_r[2]) &&
      afe_ctl.press_in_under_en == $past(mask_r[1]) &&
      afe_ctl.press_in_over_en == $past(mask_r[0]);
  endproperty
  a_in_det: assert property (p_in_det) else $error("input detection mismatch");

  property p_pulls;
    ##1 pullup_off_r == $past(cfg_r[6]) && pulldown_off_r == $past(cfg_r[5]);
  endproperty
  a_pulls: assert property (p_pulls) else $error("pull disable mismatch");

  property p_rsvd_flag;
    wr_fire && idx == FED_IDX_MODE && wbyte[1] |=> status[FED_EV_RSVD];
  endproperty
  a_rsvd_flag: assert property (p_rsvd_flag) else $error("reserved write not flagged");

endmodule
`default_nettype wire

// [tb/fed_afe_model.sv]
/*
  Far-side model of the analog front end: turns the excitation selects into
  the current drawn. Assumes static control levels from fed_top.
*/
`timescale 1ns/1ps
`default_nettype none
module fed_afe_model
  import fed_pkg::*;
(
  input wire fed_afe_ctl_t afe_ctl,
  output logic [9:0] exc_ua,
  output logic src_bad
);
  always_comb
  begin
    case (afe_ctl.exc_onehot)
      4'h1: exc_ua = 10'h019;
      4'h2: exc_ua = 10'h032;
      4'h4: exc_ua = 10'h064;
      4'h8: exc_ua = 10'h1F4;
      default: exc_ua = 10'h000;
    endcase
    // An off source with a select still high would leak current
    src_bad = (afe_ctl.exc_off && afe_ctl.exc_onehot != 4'h0) ||
      (!afe_ctl.exc_off && exc_ua == 10'h000);
  end
endmodule
`default_nettype wire

// [tb/sensor_frontend_diag_config_bench.sv]
/*
  Self-checking bench for fed_top over APB with the front-end model on its
  control outputs. Assumes an APB slave on clk; the master waits for pready.
*/
`timescale 1ns/1ps
`default_nettype none
module sensor_frontend_diag_config_bench;
  import fed_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, irq, src_bad;
  logic [31:0] prdata, q;
  logic e;
  logic [9:0] exc_ua;
  fed_afe_ctl_t afe_ctl;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [9:0] ua_tab [4] = '{10'h019, 10'h032, 10'h064, 10'h1F4};

  fed_top fed_top_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .irq(irq), .afe_ctl(afe_ctl));
  fed_afe_model fed_afe_model_i (.afe_ctl(afe_ctl), .exc_ua(exc_ua), .src_bad(src_bad));

  always #50 clk = ~clk;

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      $display("[FAIL] timeout expected 0 seen %0d", cycles);
      bad_count = bad_count + 1;
      tally_and_finish;
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      bad_count = bad_count + 1;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      chk("pready", 32'h1, 32'h0);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {2'h0, idx, 2'h0}, d);
    chk("wr_err", 32'h0, {31'h0, e});
  endtask

  task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, {2'h0, idx, 2'h0}, 8'h00);
    chk(nm, exp, q);
  endtask

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  function automatic logic [6:0] det(input fed_afe_ctl_t a);
    return {a.temp_out_under_en, a.temp_out_over_en, a.press_out_under_en,
      a.press_out_over_en, a.temp_in_over_en, a.press_in_under_en, a.press_in_over_en};
  endfunction

  task automatic t_reset;
    #1;
    chk("exc_off", 32'h1, {31'h0, afe_ctl.exc_off});
    chk("onehot", 32'h0, {28'h0, afe_ctl.exc_onehot});
    chk("route_ext", 32'h1, {31'h0, afe_ctl.route_ext});
    chk("route_int", 32'h0, {31'h0, afe_ctl.route_int});
    chk("mode", 32'h0, {31'h0, afe_ctl.temp_stage_mode_bit});
    chk("diag_on", 32'h0, {31'h0, afe_ctl.diag_global_on});
    chk("det", 32'h0, {25'h0, det(afe_ctl)});
    chk("pulls", 32'h0, {30'h0, afe_ctl.temp_pullup_off, afe_ctl.press_pulldown_off});
    chk("thr_pull", {27'h0, FED_RST_CFG[4:0]},
      {27'h0, afe_ctl.diag_threshold_sel, afe_ctl.diag_pull_strength});
    chk("irq", 32'h0, {31'h0, irq});
    rdc("mode_rst", FED_IDX_MODE, 32'h00);
    rdc("diag_rst", FED_IDX_DIAG, 32'h00);
    rdc("cfg_rst", FED_IDX_CFG, 32'h07);
    rdc("mask_rst", FED_IDX_MASK, 32'h33);
    rdc("temp_rst", FED_IDX_TEMP, 32'h40);
    rdc("stat_rst", FED_IDX_STAT, 32'h00);
    rdc("ien_rst", FED_IDX_IEN, 32'h00);
    $display("reset test done");
  endtask

  // Synchronous reset in mid-run must restore every register and output
  task automatic t_midrst;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    $display("mid-run reset test done");
  endtask

  task automatic t_exc;
    for (int c = 0; c < 8; c++)
    begin
      wr(FED_IDX_TEMP, {1'b0, c[2:0], 4'h0});
      settle;
      chk("exc_off", {31'h0, c[2]}, {31'h0, afe_ctl.exc_off});
      chk("onehot", c[2] ? 32'h0 : 32'h1 << c, {28'h0, afe_ctl.exc_onehot});
      chk("exc_ua", c[2] ? 32'h0 : {22'h0, ua_tab[c[1:0]]}, {22'h0, exc_ua});
      chk("src_bad", 32'h0, {31'h0, src_bad});
    end
    $display("excitation test done");
  endtask

  task automatic t_sel;
    wr(FED_IDX_TEMP, 8'h43);
    settle;
    rdc("temp_rd", FED_IDX_TEMP, 32'h43);
    chk("route_int", 32'h1, {31'h0, afe_ctl.route_int});
    chk("route_ext", 32'h0, {31'h0, afe_ctl.route_ext});
    wr(FED_IDX_TEMP, 8'h45);
    settle;
    chk("safe_rt", 32'h0, {30'h0, afe_ctl.route_ext, afe_ctl.route_int});
    wr(FED_IDX_TEMP, 8'h40);
    settle;
    chk("route_ext", 32'h1, {31'h0, afe_ctl.route_ext});
    $display("selector test done");
  endtask

  task automatic t_mode_diag;
    logic [7:0] m;
    wr(FED_IDX_MODE, 8'h01);
    settle;
    chk("mode", 32'h1, {31'h0, afe_ctl.temp_stage_mode_bit});
    wr(FED_IDX_MODE, 8'h00);
    settle;
    chk("mode", 32'h0, {31'h0, afe_ctl.temp_stage_mode_bit});
    wr(FED_IDX_DIAG, 8'h01);
    for (int b = 0; b < 8; b++)
    begin
      if (b != 3)
      begin
        m = 8'h01 << b;
        wr(FED_IDX_MASK, m);
        settle;
        chk("det_bit", {25'h0, m[7:4], m[2:0]}, {25'h0, det(afe_ctl)});
      end
    end
    wr(FED_IDX_MASK, 8'hF7);
    wr(FED_IDX_DIAG, 8'h00);
    settle;
    chk("diag_on", 32'h0, {31'h0, afe_ctl.diag_global_on});
    chk("det_off", 32'h0, {25'h0, det(afe_ctl)});
    wr(FED_IDX_DIAG, 8'h01);
    settle;
    chk("diag_on", 32'h1, {31'h0, afe_ctl.diag_global_on});
    chk("det_all", 32'h7F, {25'h0, det(afe_ctl)});
    wr(FED_IDX_CFG, 8'h40);
    settle;
    chk("pulls", 32'h2, {30'h0, afe_ctl.temp_pullup_off, afe_ctl.press_pulldown_off});
    wr(FED_IDX_CFG, 8'h20);
    settle;
    chk("pulls", 32'h1, {30'h0, afe_ctl.temp_pullup_off, afe_ctl.press_pulldown_off});
    wr(FED_IDX_CFG, 8'h16);
    settle;
    chk("thr_pull", 32'h16, {27'h0, afe_ctl.diag_threshold_sel, afe_ctl.diag_pull_strength});
    chk("pulls", 32'h0, {30'h0, afe_ctl.temp_pullup_off, afe_ctl.press_pulldown_off});
    $display("mode and diagnostics test done");
  endtask

  task automatic t_irq;
    wr(FED_IDX_CLR, 8'h07);
    wr(FED_IDX_IEN, 8'h02);
    settle;
    chk("irq", 32'h0, {31'h0, irq});
    wr(FED_IDX_TEMP, 8'h45);
    settle;
    chk("irq", 32'h1, {31'h0, irq});
    rdc("stat", FED_IDX_STAT, 32'h02);
    wr(FED_IDX_IEN, 8'h00);
    settle;
    chk("irq_mask", 32'h0, {31'h0, irq});
    wr(FED_IDX_IEN, 8'h02);
    wr(FED_IDX_CLR, 8'h02);
    settle;
    chk("irq_clr", 32'h0, {31'h0, irq});
    rdc("stat_clr", FED_IDX_STAT, 32'h00);
    rdc("clr_rd", FED_IDX_CLR, 32'h00);
    // Deliberate nonzero reserved bit: not stored, flagged in status
    wr(FED_IDX_MODE, 8'h02);
    rdc("mode_rsv", FED_IDX_MODE, 32'h00);
    rdc("stat_rsv", FED_IDX_STAT, 32'h01);
    wr(FED_IDX_IEN, 8'h04);
    wr(FED_IDX_MASK, FED_RST_MASK);
    settle;
    chk("irq_diag", 32'h1, {31'h0, irq});
    rdc("stat_diag", FED_IDX_STAT, 32'h05);
    rdc("ien_rd", FED_IDX_IEN, 32'h04);
    apb(1'b1, 12'h004, 8'hFF);
    chk("unmap_err", 32'h1, {31'h0, e});
    apb(1'b0, 12'h004, 8'h00);
    chk("unmap_err", 32'h1, {31'h0, e});
    chk("unmap_rd", 32'h0, q);
    $display("interrupt and bus error test done");
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_exc;
    t_sel;
    t_mode_diag;
    t_irq;
    t_midrst;
    tally_and_finish;
  end
endmodule
`default_nettype wire
